// file: common/ext_page_pkg.sv
// Purpose: Shared constants and types for the extended page 1 control block
// Assumes: 50 MHz system clock, 5-bit management register index
// Notes: Times are kept in their own unit; cycle counts derive from them
package ext_page_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [4:0] REG_PAGED_LO = 5'h10;
  localparam logic [4:0] REG_TIMER = 5'h14;
  localparam logic [4:0] REG_PWRCRC = 5'h17;
  localparam logic [4:0] REG_GENCTL = 5'h1d;
  localparam logic [4:0] REG_GENPAY = 5'h1e;
  localparam logic [4:0] REG_PAGE = 5'h1f;
  localparam logic [15:0] PAGE_MAIN = 16'h0000;
  localparam logic [15:0] PAGE_EXT1 = 16'h0001;
  localparam logic [15:0] PAGE_EXT2 = 16'h0002;
  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int SLP_LO = 13;
  localparam int WAK_LO = 11;
  localparam int SLOWMDC = 10;
  localparam int NOPRE = 5;
  localparam int PD_EN = 10;
  localparam int GEN_EN = 15;
  localparam int GEN_RUN = 14;
  localparam int GEN_DUR = 13;
  localparam int LEN_LO = 11;
  localparam int GAP_LONG = 10;
  localparam int DA_LO = 6;
  localparam int SA_LO = 2;
  localparam int PAY_RND = 1;
  localparam int BAD_FCS = 0;
  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [1:0] SLP_RST = 2'h1;
  localparam logic [1:0] WAK_RST = 2'h0;
  localparam logic [15:0] GENCTL_RST = 16'h0040;
  localparam logic [15:0] GENPAY_RST = 16'h0000;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_HZ = 50_000_000;
  localparam int CLK_NS = 20;
  localparam int SLEEP_UNIT_S = 1;
  localparam int SLEEP_UNIT_CYC = SLEEP_UNIT_S * CLK_HZ;
  localparam int MS_CYC = CLK_HZ / 1000;
  localparam int WAKE0_MS = 160;
  localparam int WAKE1_MS = 400;
  localparam int WAKE2_MS = 800;
  localparam int WAKE3_MS = 2000;
  localparam int GAP_SHORT_NS = 96;
  localparam int GAP_LONG_NS = 8192;
  localparam int GAP_SHORT_CYC = (GAP_SHORT_NS + CLK_NS - 1) / CLK_NS;
  localparam int GAP_LONG_CYC = (GAP_LONG_NS + CLK_NS - 1) / CLK_NS;
  // ****************************************************************
  // Test frame layout
  // ****************************************************************
  localparam logic [13:0] LEN0 = 14'd125;
  localparam logic [13:0] LEN1 = 14'd64;
  localparam logic [13:0] LEN2 = 14'd1518;
  localparam logic [13:0] LEN3 = 14'd10000;
  localparam logic [13:0] BLOCK_PKTS = 14'd10000;
  localparam int BURST_PKTS = 30_000_000;
  localparam logic [11:0] BURST_BLOCKS = 12'(BURST_PKTS / 10000);
  localparam logic [13:0] PRE_BYTES = 14'd8;
  localparam logic [13:0] HDR_BYTES = 14'd12;
  localparam logic [13:0] FCS_BYTES = 14'd4;
  localparam logic [7:0] PRE_BYTE = 8'h55;
  localparam logic [7:0] SFD_BYTE = 8'hd5;
  localparam logic [31:0] CRC_POLY = 32'hedb88320;
  localparam logic [31:0] CRC_INIT = 32'hffffffff;
  localparam logic [15:0] LFSR_SEED = 16'hace1;
  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic rd;
    logic wr;
    logic [4:0] addr;
    logic [15:0] wdata;
  } regReq_t;
  typedef struct packed {
    logic en;
    logic er;
    logic lpi;
    logic [7:0] data;
  } txMii_t;
  typedef enum logic [2:0] {GS_IDLE, GS_PRE, GS_BODY, GS_FCS, GS_GAP, GS_DONE} genState_t;
endpackage

// file: core/ext_page_ctrl.sv
// Purpose: Extended page 1 registers, low-power timers and test frame generator
// Assumes: Registers reached over a plain strobe port, read data one cycle later
// Notes: Page 2 registers live outside; page2Access tells them to answer
// Contract
// - Sleep timer 1-4 s, default 01, sticky
// - Wake timer 160/400/800 ms or 2 s
// - Slow management clock hint bit, sticky
// - Media status reports none or copper
// - No-preamble mode raises receive valid anyway
// - Read back internal management address
// - Inline power status valid while enabled
// - CRC error counter clears when read
// - Frames only while enable and run set
// - Continuous blocks of 10000 or 30M stop
// - Continuous off stops at block boundary
// - Frame length 125/64/1518/10000 bytes
// - Gap 8192 ns or 96 ns
// - Destination low nibble, default 0001
// - Source low nibble, default 0000
// - Payload random or fixed pattern
// - Good or deliberately bad FCS
// - Control changes apply after run restart
// - Pattern register repeats through payload
// - Pattern change applies after run restart
// - Page 2 select remaps registers 16-30
// - Page 0 select restores main space
// - Force-LPI sends idle power, ignores MAC, only while generator enable set
`timescale 1ns/1ps
`default_nettype none
module ext_page_ctrl #(
  parameter int SLEEP_CYC = ext_page_pkg::SLEEP_UNIT_CYC,
  parameter int WAKE_MS_CYC = ext_page_pkg::MS_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire ext_page_pkg::regReq_t req,
  output logic [15:0] rdData,
  input wire logic softReset,
  input wire logic [4:0] phyAddr,
  input wire logic copperSel,
  input wire logic [1:0] pdResult,
  output logic pdEnable,
  input wire logic crcErr,
  input wire logic energyDetect,
  output logic sleepMode,
  output logic wakePulse,
  output logic slowMdc,
  input wire logic rxCarrier,
  input wire logic rxSfdSeen,
  output logic rxDv,
  input wire logic forceLpi,
  input wire ext_page_pkg::txMii_t macTx,
  output ext_page_pkg::txMii_t tx,
  output logic page2Access
);
  // ****************************************************************
  // Reset release and pin synchronisers
  // ****************************************************************
  logic [1:0] rstPipe;
  logic rstn;
  logic energyMeta;
  logic energySync;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rstPipe <= 2'h0;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rstn = rstPipe[1];
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      energyMeta <= 1'b0;
      energySync <= 1'b0;
    end else begin
      energyMeta <= energyDetect;
      energySync <= energyMeta;
    end
  end
  // ****************************************************************
  // Register decode
  // ****************************************************************
  logic [15:0] page;
  logic [1:0] sleepSel;
  logic [1:0] wakeSel;
  logic noPre;
  logic [7:0] crcCount;
  logic [15:0] genCtl;
  logic [15:0] genPay;
  wire page1 = (page == ext_page_pkg::PAGE_EXT1);
  wire wrTimer = req.wr && page1 && req.addr == ext_page_pkg::REG_TIMER;
  wire wrPwr = req.wr && page1 && req.addr == ext_page_pkg::REG_PWRCRC;
  wire wrGen = req.wr && page1 && req.addr == ext_page_pkg::REG_GENCTL;
  wire wrPay = req.wr && page1 && req.addr == ext_page_pkg::REG_GENPAY;
  wire wrPage = req.wr && req.addr == ext_page_pkg::REG_PAGE;
  wire rdPwr = req.rd && page1 && req.addr == ext_page_pkg::REG_PWRCRC;
  wire [1:0] mediaField = {1'b0, copperSel};
  wire [1:0] pdField = pdEnable ? pdResult : 2'h0;
  wire [15:0] timerView = {1'b0, sleepSel, wakeSel, slowMdc, 2'h0, mediaField, noPre, 5'h0};
  wire [15:0] pwrView = {phyAddr, pdEnable, pdField, crcCount};
  wire [15:0] pagedView =
    (req.addr == ext_page_pkg::REG_TIMER) ? timerView :
    (req.addr == ext_page_pkg::REG_PWRCRC) ? pwrView :
    (req.addr == ext_page_pkg::REG_GENCTL) ? genCtl :
    (req.addr == ext_page_pkg::REG_GENPAY) ? genPay : 16'h0000;
  // Page 2 and main-space contents answer elsewhere, so they read zero here
  wire [15:0] rdView =
    (req.addr == ext_page_pkg::REG_PAGE) ? page :
    (page1 && req.addr >= ext_page_pkg::REG_PAGED_LO) ? pagedView : 16'h0000;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdData <= 16'h0000;
    end else begin
      rdData <= req.rd ? rdView : 16'h0000;
    end
  end
  // ****************************************************************
  // Page select
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      page <= ext_page_pkg::PAGE_MAIN;
      page2Access <= 1'b0;
    end else if (wrPage) begin
      page <= req.wdata;
      page2Access <= (req.wdata == ext_page_pkg::PAGE_EXT2);
    end
  end
  // ****************************************************************
  // Sticky configuration, kept across soft reset
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sleepSel <= ext_page_pkg::SLP_RST;
      wakeSel <= ext_page_pkg::WAK_RST;
      slowMdc <= 1'b0;
      noPre <= 1'b0;
      pdEnable <= 1'b0;
    end else begin
      if (wrTimer) begin
        sleepSel <= req.wdata[ext_page_pkg::SLP_LO +: 2];
        wakeSel <= req.wdata[ext_page_pkg::WAK_LO +: 2];
        slowMdc <= req.wdata[ext_page_pkg::SLOWMDC];
        noPre <= req.wdata[ext_page_pkg::NOPRE];
      end
      if (wrPwr) begin
        pdEnable <= req.wdata[ext_page_pkg::PD_EN];
      end
    end
  end
  // ****************************************************************
  // Generator control, cleared by soft reset
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      genCtl <= ext_page_pkg::GENCTL_RST;
      genPay <= ext_page_pkg::GENPAY_RST;
    end else if (softReset) begin
      genCtl <= ext_page_pkg::GENCTL_RST;
      genPay <= ext_page_pkg::GENPAY_RST;
    end else begin
      if (wrGen) begin
        genCtl <= req.wdata;
      end
      if (wrPay) begin
        genPay <= req.wdata;
      end
    end
  end
  // ****************************************************************
  // CRC error counter
  // ****************************************************************
  // Saturates rather than wrapping so a burst is never mistaken for quiet
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      crcCount <= 8'h00;
    end else if (rdPwr) begin
      crcCount <= crcErr ? 8'h01 : 8'h00;
    end else if (crcErr && crcCount != 8'hff) begin
      crcCount <= crcCount + 8'h01;
    end
  end
  // ****************************************************************
  // Low-power sleep and wake timers
  // ****************************************************************
  function automatic logic [31:0] wakeMs(input logic [1:0] sel);
    case (sel)
      2'h0: wakeMs = 32'(ext_page_pkg::WAKE0_MS);
      2'h1: wakeMs = 32'(ext_page_pkg::WAKE1_MS);
      2'h2: wakeMs = 32'(ext_page_pkg::WAKE2_MS);
      default: wakeMs = 32'(ext_page_pkg::WAKE3_MS);
    endcase
  endfunction
  logic [31:0] lpCount;
  wire [31:0] sleepLim = 32'((32'(sleepSel) + 32'h1) * 32'(SLEEP_CYC));
  wire [31:0] wakeLim = 32'(wakeMs(wakeSel) * 32'(WAKE_MS_CYC));
  wire sleepDue = !sleepMode && lpCount == sleepLim - 32'h1;
  wire wakeDue = sleepMode && lpCount == wakeLim - 32'h1;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lpCount <= 32'h0;
      sleepMode <= 1'b0;
      wakePulse <= 1'b0;
    end else if (energySync) begin
      lpCount <= 32'h0;
      sleepMode <= 1'b0;
      wakePulse <= 1'b0;
    end else begin
      lpCount <= (sleepDue || wakeDue) ? 32'h0 : lpCount + 32'h1;
      sleepMode <= sleepMode || sleepDue;
      wakePulse <= wakeDue;
    end
  end
  // ****************************************************************
  // 10BASE-T receive valid
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rxDv <= 1'b0;
    end else begin
      rxDv <= rxCarrier && (noPre || rxSfdSeen);
    end
  end
  // ****************************************************************
  // Test frame generator
  // ****************************************************************
  function automatic logic [31:0] crcByte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ ext_page_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction
  ext_page_pkg::genState_t st;
  logic [13:0] cfg;
  logic [15:0] pat;
  logic [13:0] idx;
  logic [31:0] crc;
  logic [15:0] lfsr;
  logic [8:0] gapCnt;
  logic [13:0] pktCnt;
  logic [11:0] blkCnt;
  logic stopAfter;
  wire genOn = genCtl[ext_page_pkg::GEN_EN] && genCtl[ext_page_pkg::GEN_RUN];
  wire [1:0] lenSel = cfg[ext_page_pkg::LEN_LO +: 2];
  wire [13:0] frameLen = (lenSel == 2'h0) ? ext_page_pkg::LEN0 :
    (lenSel == 2'h1) ? ext_page_pkg::LEN1 :
    (lenSel == 2'h2) ? ext_page_pkg::LEN2 : ext_page_pkg::LEN3;
  wire [13:0] bodyLen = frameLen - ext_page_pkg::FCS_BYTES;
  wire [8:0] gapLoad = cfg[ext_page_pkg::GAP_LONG] ?
    9'(ext_page_pkg::GAP_LONG_CYC - 1) : 9'(ext_page_pkg::GAP_SHORT_CYC - 1);
  wire [13:0] payIdx = idx - ext_page_pkg::HDR_BYTES;
  wire [7:0] fixedByte = payIdx[0] ? pat[7:0] : pat[15:8];
  wire [7:0] payByte = cfg[ext_page_pkg::PAY_RND] ? lfsr[7:0] : fixedByte;
  wire [7:0] bodyByte =
    (idx == 14'd5) ? {4'hf, cfg[ext_page_pkg::DA_LO +: 4]} :
    (idx == 14'd11) ? {4'hf, cfg[ext_page_pkg::SA_LO +: 4]} :
    (idx < ext_page_pkg::HDR_BYTES) ? 8'hff : payByte;
  // Bad FCS keeps the raw remainder, which never matches a good check
  wire [31:0] fcsWord = cfg[ext_page_pkg::BAD_FCS] ? crc : ~crc;
  wire [7:0] preByte = (idx == ext_page_pkg::PRE_BYTES - 14'd1) ?
    ext_page_pkg::SFD_BYTE : ext_page_pkg::PRE_BYTE;
  wire [7:0] genByte = (st == ext_page_pkg::GS_PRE) ? preByte :
    (st == ext_page_pkg::GS_BODY) ? bodyByte : fcsWord[8 * idx[1:0] +: 8];
  wire genEn = st == ext_page_pkg::GS_PRE || st == ext_page_pkg::GS_BODY ||
    st == ext_page_pkg::GS_FCS;
  wire blockEnd = pktCnt == ext_page_pkg::BLOCK_PKTS - 14'd1;
  // Continuous mode re-reads the live bit at each block boundary
  wire stopNext = blockEnd && (cfg[ext_page_pkg::GEN_DUR] ?
    !genCtl[ext_page_pkg::GEN_DUR] :
    blkCnt == ext_page_pkg::BURST_BLOCKS - 12'h1);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st <= ext_page_pkg::GS_IDLE;
      cfg <= 14'h0;
      pat <= 16'h0;
      idx <= 14'h0;
      crc <= ext_page_pkg::CRC_INIT;
      lfsr <= ext_page_pkg::LFSR_SEED;
      gapCnt <= 9'h0;
      pktCnt <= 14'h0;
      blkCnt <= 12'h0;
      stopAfter <= 1'b0;
    end else if (!genOn) begin
      st <= ext_page_pkg::GS_IDLE;
    end else begin
      unique case (st)
        ext_page_pkg::GS_IDLE: begin
          cfg <= genCtl[13:0];
          pat <= genPay;
          idx <= 14'h0;
          pktCnt <= 14'h0;
          blkCnt <= 12'h0;
          stopAfter <= 1'b0;
          st <= ext_page_pkg::GS_PRE;
        end
        ext_page_pkg::GS_PRE: begin
          idx <= idx + 14'h1;
          crc <= ext_page_pkg::CRC_INIT;
          if (idx == ext_page_pkg::PRE_BYTES - 14'd1) begin
            idx <= 14'h0;
            st <= ext_page_pkg::GS_BODY;
          end
        end
        ext_page_pkg::GS_BODY: begin
          crc <= crcByte(crc, bodyByte);
          idx <= idx + 14'h1;
          if (idx >= ext_page_pkg::HDR_BYTES) begin
            lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
          end
          if (idx == bodyLen - 14'd1) begin
            idx <= 14'h0;
            st <= ext_page_pkg::GS_FCS;
          end
        end
        ext_page_pkg::GS_FCS: begin
          idx <= idx + 14'h1;
          if (idx == ext_page_pkg::FCS_BYTES - 14'd1) begin
            idx <= 14'h0;
            gapCnt <= gapLoad;
            stopAfter <= stopNext;
            pktCnt <= blockEnd ? 14'h0 : pktCnt + 14'h1;
            blkCnt <= blockEnd ? blkCnt + 12'h1 : blkCnt;
            st <= ext_page_pkg::GS_GAP;
          end
        end
        ext_page_pkg::GS_GAP: begin
          gapCnt <= gapCnt - 9'h1;
          if (gapCnt == 9'h0) begin
            st <= stopAfter ? ext_page_pkg::GS_DONE : ext_page_pkg::GS_PRE;
          end
        end
        ext_page_pkg::GS_DONE: begin
          st <= ext_page_pkg::GS_DONE;
        end
      endcase
    end
  end
  // ****************************************************************
  // Transmit path select
  // ****************************************************************
  ext_page_pkg::txMii_t next_tx;
  wire lpiOn = genCtl[ext_page_pkg::GEN_EN] && forceLpi;
  assign next_tx = lpiOn ? '{en: 1'b0, er: 1'b0, lpi: 1'b1, data: 8'h00} :
    genCtl[ext_page_pkg::GEN_EN] ? '{en: genEn, er: 1'b0, lpi: 1'b0, data: genByte} :
    macTx;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx <= '0;
    end else begin
      tx <= next_tx;
    end
  end
  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence gapStart;
    st == ext_page_pkg::GS_GAP && $past(st) == ext_page_pkg::GS_FCS;
  endsequence
  sequence gapHold;
    (st == ext_page_pkg::GS_GAP || !genOn)[*5] ##1 st != ext_page_pkg::GS_GAP;
  endsequence
  a_page_two_map: assert property (@(posedge clk) disable iff (!rstn)
    wrPage && req.wdata == ext_page_pkg::PAGE_EXT2 |=> page2Access && !page1)
    else $error("page 2 select did not take");
  a_page_main_back: assert property (@(posedge clk) disable iff (!rstn)
    wrPage && req.wdata == ext_page_pkg::PAGE_MAIN |=> !page2Access ##1 rdData == 16'h0000
      || req.rd)
    else $error("main page not restored");
  a_crc_read_clear: assert property (@(posedge clk) disable iff (!rstn)
    rdPwr && !crcErr |=> crcCount == 8'h00 && rdData[7:0] == $past(crcCount))
    else $error("error counter not cleared by read");
  a_gen_halt_idle: assert property (@(posedge clk) disable iff (!rstn)
    !genOn |=> st == ext_page_pkg::GS_IDLE ##1 !tx.en || $past(!genCtl[ext_page_pkg::GEN_EN]))
    else $error("generator running without enable and run");
  a_short_gap_len: assert property (@(posedge clk) disable iff (!rstn)
    gapStart and !cfg[ext_page_pkg::GAP_LONG] |-> gapHold)
    else $error("short gap length wrong");
  a_rxdv_no_pre: assert property (@(posedge clk) disable iff (!rstn)
    rxCarrier && noPre |=> rxDv)
    else $error("receive valid missing in no-preamble mode");
  a_lpi_force_out: assert property (@(posedge clk) disable iff (!rstn)
    genCtl[ext_page_pkg::GEN_EN] && forceLpi |=> tx.lpi && !tx.en)
    else $error("forced idle power not sent");
  a_mac_blocked: assert property (@(posedge clk) disable iff (!rstn)
    genCtl[ext_page_pkg::GEN_EN] && !forceLpi && !genEn && macTx.en |=> !tx.en)
    else $error("MAC data leaked while generator enabled");
  a_cfg_snapshot: assert property (@(posedge clk) disable iff (!rstn)
    st != ext_page_pkg::GS_IDLE && $past(st) != ext_page_pkg::GS_IDLE && genOn
      |-> $stable(cfg) && $stable(pat))
    else $error("generator settings changed mid-run");
endmodule
`default_nettype wire

// file: dv/mgmt_host.sv
// Purpose: Management host model driving the register strobe port
// Assumes: Read data stands only in the cycle after the read strobe
// Notes: Strobes are one cycle long and change just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module mgmt_host (
  input wire logic clk,
  output var ext_page_pkg::regReq_t req,
  input wire logic [15:0] rdData
);
  initial req = '0;
  // ****************************************************************
  // Bus cycles
  // ****************************************************************
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge clk);
    req <= '0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk);
    req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
    @(posedge clk);
    req <= '0;
    #1 d = rdData;
  endtask
  // Clearing run then setting it again passes through idle, where new settings land
  task automatic restart(input logic [15:0] ctl);
    wr(ext_page_pkg::REG_GENCTL, ctl & 16'hbfff);
    wr(ext_page_pkg::REG_GENCTL, ctl);
  endtask
endmodule
`default_nettype wire

// file: dv/testbench.sv
// Purpose: Self-checking bench for the extended page 1 block
// Assumes: Sleep unit shortened to 100 cycles, wake unit to 2 cycles
// Notes: Soft reset pulsed once to show sticky bits survive it
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk, resetn, crcErr, energyDetect, sleepMode, wakePulse, slowMdc;
  logic rxCarrier, rxSfdSeen, rxDv, forceLpi, pdEnable, page2Access, softReset, copperSel;
  logic [15:0] rdData, d;
  ext_page_pkg::regReq_t req;
  ext_page_pkg::txMii_t macTx, tx;
  int err_total = 0;
  int cmp_count = 0;
  logic [7:0] b [0:71];
  int n, k;
  mgmt_host host (.clk(clk), .req(req), .rdData(rdData));
  ext_page_ctrl #(.SLEEP_CYC(100), .WAKE_MS_CYC(2)) DUT (.clk(clk), .resetn(resetn),
    .req(req), .rdData(rdData), .softReset(softReset), .phyAddr(5'h0b), .copperSel(copperSel),
    .pdResult(2'h2), .pdEnable(pdEnable), .crcErr(crcErr), .energyDetect(energyDetect),
    .sleepMode(sleepMode), .wakePulse(wakePulse), .slowMdc(slowMdc),
    .rxCarrier(rxCarrier), .rxSfdSeen(rxSfdSeen), .rxDv(rxDv), .forceLpi(forceLpi),
    .macTx(macTx), .tx(tx), .page2Access(page2Access));
  // ****************************************************************
  // Helpers
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic step(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_regs;
    host.rd(ext_page_pkg::REG_TIMER, d); chk("timer", 16'h2040, d);
    host.rd(ext_page_pkg::REG_GENCTL, d); chk("genctl", 16'h0040, d);
    host.rd(ext_page_pkg::REG_GENPAY, d); chk("genpay", 16'h0000, d);
    host.wr(ext_page_pkg::REG_TIMER, 16'h0420);
    host.rd(ext_page_pkg::REG_TIMER, d); chk("timer wr", 16'h0460, d);
    chk("slowmdc", 16'h0001, {15'h0, slowMdc});
    @(posedge clk) copperSel <= 1'b0;
    host.rd(ext_page_pkg::REG_TIMER, d);
    chk("media none", 16'h0420, d);
    host.wr(ext_page_pkg::REG_GENCTL, 16'h0100);
    @(posedge clk) softReset <= 1'b1;
    @(posedge clk) softReset <= 1'b0;
    host.rd(ext_page_pkg::REG_GENCTL, d);
    chk("genctl srst", 16'h0040, d);
    host.rd(ext_page_pkg::REG_TIMER, d);
    chk("timer srst", 16'h0420, d);
  endtask
  task automatic t_crc;
    host.rd(ext_page_pkg::REG_PWRCRC, d);
    chk("pd off", 16'h5800, d);
    host.wr(ext_page_pkg::REG_PWRCRC, 16'hffff);
    repeat (3) begin
      @(posedge clk) crcErr <= 1'b1;
      @(posedge clk) crcErr <= 1'b0;
    end
    chk("pden", 16'h0001, {15'h0, pdEnable});
    host.rd(ext_page_pkg::REG_PWRCRC, d); chk("crc", 16'h5e03, d);
    host.rd(ext_page_pkg::REG_PWRCRC, d); chk("crc clr", 16'h5e00, d);
  endtask
  task automatic t_rx_sleep;
    @(posedge clk) rxCarrier <= 1'b1;
    step(2); chk("rxdv", 16'h0001, {15'h0, rxDv});
    @(posedge clk) energyDetect <= 1'b0;
    step(90); chk("awake", 16'h0000, {15'h0, sleepMode});
    step(25); chk("asleep", 16'h0001, {15'h0, sleepMode});
    n = 0;
    while (wakePulse !== 1'b1 && n < 340) begin step(1); n++; end
    chk("wake", 16'h0001, {15'h0, wakePulse});
  endtask
  task automatic t_gen;
    @(posedge clk) macTx <= '{en: 1'b1, er: 1'b0, lpi: 1'b0, data: 8'h3c};
    host.wr(ext_page_pkg::REG_GENPAY, 16'ha5c3);
    host.restart(16'hc840);
    n = 0;
    while (tx.en !== 1'b1 && n < 20) begin step(1); n++; end
    k = 0;
    for (int i = 0; i < 72; i++) begin
      b[i] = tx.data;
      if (tx.en === 1'b1) k++;
      step(1);
    end
    chk("frame", 16'd72, 16'(k));
    chk("pre", 16'h55d5, {b[0], b[7]});
    chk("da", 16'hfff1, {b[8], b[13]});
    chk("sa", 16'hfff0, {b[14], b[19]});
    chk("pay", 16'ha5c3, {b[20], b[21]});
    n = 0;
    while (tx.en !== 1'b1 && n < 20) begin step(1); n++; end
    chk("gap", 16'd5, 16'(n));
    host.wr(ext_page_pkg::REG_GENCTL, 16'hc880);
    n = 0;
    while (tx.en === 1'b1 && n < 80) begin step(1); n++; end
    n = 0;
    while (tx.en !== 1'b1 && n < 20) begin step(1); n++; end
    step(13);
    chk("da held", 16'h00f1, {8'h0, tx.data});
    @(posedge clk) forceLpi <= 1'b1;
    host.wr(ext_page_pkg::REG_GENCTL, 16'h8840);
    step(2); chk("lpi", 16'h0002, {14'h0, tx.lpi, tx.en});
    @(posedge clk) forceLpi <= 1'b0;
    macTx <= '{en: 1'b1, er: 1'b0, lpi: 1'b0, data: 8'h3c};
    host.wr(ext_page_pkg::REG_GENCTL, 16'h0040);
    step(2); chk("mac", 16'h013c, {7'h0, tx.en, tx.data});
  endtask
  task automatic t_pages;
    host.wr(ext_page_pkg::REG_PAGE, ext_page_pkg::PAGE_EXT2);
    step(1); chk("pg2", 16'h0001, {15'h0, page2Access});
    host.rd(ext_page_pkg::REG_GENCTL, d); chk("pg2 rd", 16'h0000, d);
    host.wr(ext_page_pkg::REG_PAGE, ext_page_pkg::PAGE_MAIN);
    host.rd(ext_page_pkg::REG_GENCTL, d); chk("pg0 rd", 16'h0000, d);
    chk("pg0", 16'h0000, {15'h0, page2Access});
    host.rd(ext_page_pkg::REG_PAGE, d);
    chk("pg reg", 16'h0000, d);
  endtask
  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    resetn = 1'b0;
    {crcErr, rxCarrier, rxSfdSeen, forceLpi, softReset} = 5'h00;
    energyDetect = 1'b1;
    copperSel = 1'b1;
    macTx = '0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    host.wr(ext_page_pkg::REG_PAGE, ext_page_pkg::PAGE_EXT1);
    t_regs();
    t_crc();
    t_rx_sleep();
    t_gen();
    t_pages();
    print_verdict();
  end
  initial begin
    #200000;
    err_total++;
    print_verdict();
  end
endmodule
`default_nettype wire
